//--- common/srw_defines.svh
// Offsets, field positions, reset values and timing counts for the SYSREF window block
//
// Contract
// - With ramping on, the applied coarse delay walks toward a new target instead of jumping.
// - Slow speed moves one coarse step per 256 clocks, fast speed four steps per 384 clocks.
// - With ramping enabled, every later write of the coarse delay field starts a new ramp.
// - SYSREF is captured on a fixed device clock edge so latency repeats from start-up to start-up.
// - Single-channel mode samples on both clock edges, halving clock rate and doubling the window.
// - The SYSREF position within the clock cycle is kept as a 24-bit vector, one bit per tap.
// - The position vector counts as valid only after at least 3 SYSREF rising edges.
// - A vector bit of 1 marks a possible setup or hold violation, 0 marks a good tap.
// - Vector bits 0 and 23 always read as 1.
// - The tap select field is the binary index of the tap at which SYSREF is latched.
// - Only taps 0 to 15 can be selected; the top eight bits are report only.
// - Tap spacing 0 gives coarser delay steps and 1 gives finer steps.
// - Each candidate sampling instant is a delayed copy of the clock rising edge.
`ifndef SRW_DEFINES_SVH
`define SRW_DEFINES_SVH

// =====================================================================
// Register indices (byte address is four times the index)
`define SRW_IDX_RAMP        10'h028
`define SRW_IDX_CTRL        10'h029
`define SRW_IDX_POS_LOW     10'h02C
`define SRW_IDX_POS_MID     10'h02D
`define SRW_IDX_POS_HIGH    10'h02E
`define SRW_IDX_WIN_STATUS  10'h02F

// =====================================================================
// Field positions
`define SRW_RAMP_COARSE_LSB 0
`define SRW_RAMP_EN_BIT     8
`define SRW_RAMP_SPEED_BIT  9
`define SRW_RAMP_APPLIED_LSB 16
`define SRW_RAMP_BUSY_BIT   24
`define SRW_CTRL_SEL_LSB    0
`define SRW_CTRL_SPACING_BIT 4
`define SRW_CTRL_SINGLE_BIT 5

// =====================================================================
// Reset values and timing counts
`define SRW_COARSE_RST      8'h00
`define SRW_SEL_RST         4'h0
`define SRW_POS_RST         24'hFFFFFF
`define SRW_SLOW_PERIOD     9'h100
`define SRW_FAST_PERIOD     9'h180
`define SRW_SLOW_STEP       8'h01
`define SRW_FAST_STEP       8'h04
`define SRW_EDGES_VALID     2'h3

`endif

//--- common/srw_pkg.sv
// Types shared by the SYSREF window block
package srw_pkg;
  typedef enum logic {SRW_RAMP_IDLE, SRW_RAMP_RUN} srw_ramp_state_t;
  typedef enum logic {SRW_SPEED_SLOW, SRW_SPEED_FAST} srw_speed_t;
endpackage

//--- logic/srw_tap_judge.sv
// One tap of the SYSREF position detector
`timescale 1ns/1ns
module srw_tap_judge
(
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic edge_i,
  input  wire logic publish_i,
  input  wire logic near_i,
  output logic      flag_o
);
  logic accum_reg;
  logic flag_reg;

  // Collect violation hints over a window, publish at its end
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      accum_reg <= 1'b0;
      flag_reg  <= 1'b1;
    end
    else if (edge_i && publish_i)
    begin
      flag_reg  <= accum_reg | near_i;
      accum_reg <= 1'b0;
    end
    else if (edge_i)
    begin
      accum_reg <= accum_reg | near_i;
    end
  end

  assign flag_o = flag_reg;
endmodule

//--- logic/srw_top.sv
// Coarse delay ramp and SYSREF windowing with an AXI4-Lite register slave
`timescale 1ns/1ns
`include "srw_defines.svh"
module srw_top
#(
  parameter int ADDR_W = 12,
  parameter int TAPS   = 24,
  parameter int SEL_W  = 4
)
(
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_awaddr_i,
  input  wire logic              s_awvalid_i,
  output logic                   s_awready_o,
  input  wire logic [31:0]       s_wdata_i,
  input  wire logic [3:0]        s_wstrb_i,
  input  wire logic              s_wvalid_i,
  output logic                   s_wready_o,
  output logic [1:0]             s_bresp_o,
  output logic                   s_bvalid_o,
  input  wire logic              s_bready_i,
  input  wire logic [ADDR_W-1:0] s_araddr_i,
  input  wire logic              s_arvalid_i,
  output logic                   s_arready_o,
  output logic [31:0]            s_rdata_o,
  output logic [1:0]             s_rresp_o,
  output logic                   s_rvalid_o,
  input  wire logic              s_rready_i,
  // Clocking side
  input  wire logic              sysref_i,
  input  wire logic [TAPS-1:0]   sysref_taps_i,
  output logic [7:0]             coarse_clock_delay_o,
  output logic                   sysref_tap_spacing_o,
  output logic                   dual_edge_sample_o,
  output logic                   sysref_capture_o,
  output logic                   sysref_latched_o
);

  // ===================================================================
  // Declarations
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  logic [ADDR_W-1:0]        aw_addr_reg;
  logic                     aw_full_reg;
  logic [31:0]              w_data_reg;
  logic [3:0]               w_strb_reg;
  logic                     w_full_reg;
  logic                     bvalid_reg;
  logic [1:0]               bresp_reg;
  logic                     rvalid_reg;
  logic [31:0]              rdata_reg;
  logic [1:0]               rresp_reg;

  logic [7:0]               target_reg;
  logic [7:0]               applied_reg;
  logic                     ramp_en_reg;
  srw_pkg::srw_speed_t      speed_reg;
  srw_pkg::srw_ramp_state_t ramp_state_reg;
  logic [8:0]               ramp_cnt_reg;
  logic [SEL_W-1:0]         sel_reg;
  logic                     spacing_reg;
  logic                     single_reg;

  logic                     sysref_d_reg;
  logic [1:0]               edge_cnt_reg;
  logic [1:0]               win_cnt_reg;
  logic                     valid_reg;
  logic                     latched_reg;
  logic                     capture_reg;
  logic [TAPS-1:0]          judge_flag;
  logic [TAPS-1:0]          near_vec;

  // ===================================================================
  // Write channel decode
  wire aw_take = s_awvalid_i && s_awready_o;
  wire w_take  = s_wvalid_i && s_wready_o;
  wire aw_have = aw_full_reg || aw_take;
  wire w_have  = w_full_reg || w_take;
  wire wr_go   = aw_have && w_have;
  wire [ADDR_W-1:0] wr_addr = aw_full_reg ? aw_addr_reg : s_awaddr_i;
  wire [31:0]       wr_data = w_full_reg ? w_data_reg : s_wdata_i;
  wire [3:0]        wr_strb = w_full_reg ? w_strb_reg : s_wstrb_i;
  wire [9:0]        wr_idx  = wr_addr[11:2];
  wire wr_ramp  = wr_go && (wr_idx == `SRW_IDX_RAMP);
  wire wr_ctrl  = wr_go && (wr_idx == `SRW_IDX_CTRL);
  wire wr_ro    = wr_go && ((wr_idx == `SRW_IDX_POS_LOW) || (wr_idx == `SRW_IDX_POS_MID)
                  || (wr_idx == `SRW_IDX_POS_HIGH) || (wr_idx == `SRW_IDX_WIN_STATUS));
  wire wr_known = wr_ramp || wr_ctrl || wr_ro;
  wire coarse_wr = wr_ramp && wr_strb[0];

  assign s_awready_o = !aw_full_reg && !bvalid_reg;
  assign s_wready_o  = !w_full_reg && !bvalid_reg;
  assign s_bvalid_o  = bvalid_reg;
  assign s_bresp_o   = bresp_reg;

  // Hold whichever half of a write arrives first
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
    end
    else
    begin
      if (aw_take)
        aw_addr_reg <= s_awaddr_i;
      if (w_take)
      begin
        w_data_reg <= s_wdata_i;
        w_strb_reg <= s_wstrb_i;
      end
      aw_full_reg <= aw_have && !wr_go;
      w_full_reg  <= w_have && !wr_go;
    end
  end

  // Write response
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_known ? RESP_OKAY : RESP_DECERR;
    end
    else if (s_bready_i)
      bvalid_reg <= 1'b0;
  end

  // ===================================================================
  // Control fields
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      ramp_en_reg <= 1'b0;
      speed_reg   <= srw_pkg::SRW_SPEED_SLOW;
      sel_reg     <= `SRW_SEL_RST;
      spacing_reg <= 1'b0;
      single_reg  <= 1'b0;
    end
    else
    begin
      if (wr_ramp && wr_strb[1])
      begin
        ramp_en_reg <= wr_data[`SRW_RAMP_EN_BIT];
        speed_reg   <= srw_pkg::srw_speed_t'(wr_data[`SRW_RAMP_SPEED_BIT]);
      end
      if (wr_ctrl && wr_strb[0])
      begin
        sel_reg     <= wr_data[`SRW_CTRL_SEL_LSB +: SEL_W];
        spacing_reg <= wr_data[`SRW_CTRL_SPACING_BIT];
        single_reg  <= wr_data[`SRW_CTRL_SINGLE_BIT];
      end
    end
  end

  // ===================================================================
  // Coarse delay ramp
  wire       ramp_up   = target_reg > applied_reg;
  wire [7:0] ramp_dist = ramp_up ? 8'(target_reg - applied_reg) : 8'(applied_reg - target_reg);
  wire [7:0] ramp_step = (speed_reg == srw_pkg::SRW_SPEED_FAST) ? `SRW_FAST_STEP
                         : `SRW_SLOW_STEP;
  wire [8:0] ramp_last = (speed_reg == srw_pkg::SRW_SPEED_FAST) ? 9'(`SRW_FAST_PERIOD - 1)
                         : 9'(`SRW_SLOW_PERIOD - 1);
  wire [7:0] ramp_move = (ramp_dist < ramp_step) ? ramp_dist : ramp_step;
  wire [7:0] ramp_next = ramp_up ? 8'(applied_reg + ramp_move) : 8'(applied_reg - ramp_move);
  wire       ramp_tick = (ramp_state_reg == srw_pkg::SRW_RAMP_RUN) && (ramp_cnt_reg == ramp_last);

  // Target write, periodic stepping toward it
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      target_reg     <= `SRW_COARSE_RST;
      applied_reg    <= `SRW_COARSE_RST;
      ramp_cnt_reg   <= 9'h000;
      ramp_state_reg <= srw_pkg::SRW_RAMP_IDLE;
    end
    else if (coarse_wr)
    begin
      target_reg   <= wr_data[`SRW_RAMP_COARSE_LSB +: 8];
      ramp_cnt_reg <= 9'h000;
      if (ramp_en_reg)
        ramp_state_reg <= srw_pkg::SRW_RAMP_RUN;
      else
      begin
        applied_reg    <= wr_data[`SRW_RAMP_COARSE_LSB +: 8];
        ramp_state_reg <= srw_pkg::SRW_RAMP_IDLE;
      end
    end
    else
    begin
      case (ramp_state_reg)
        srw_pkg::SRW_RAMP_IDLE:
          ramp_cnt_reg <= 9'h000;
        srw_pkg::SRW_RAMP_RUN:
        begin
          if (ramp_tick)
          begin
            applied_reg  <= ramp_next;
            ramp_cnt_reg <= 9'h000;
            if (ramp_next == target_reg)
              ramp_state_reg <= srw_pkg::SRW_RAMP_IDLE;
          end
          else
            ramp_cnt_reg <= 9'(ramp_cnt_reg + 9'h001);
        end
        default:
          ramp_state_reg <= srw_pkg::SRW_RAMP_IDLE;
      endcase
    end
  end

  assign coarse_clock_delay_o = applied_reg;

  // ===================================================================
  // SYSREF position detector
  wire sysref_rise = sysref_i && !sysref_d_reg;
  wire win_last    = (win_cnt_reg == 2'(`SRW_EDGES_VALID - 1));

  // Edge counting for validity and window refresh
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      sysref_d_reg <= 1'b0;
      edge_cnt_reg <= 2'h0;
      win_cnt_reg  <= 2'h0;
      valid_reg    <= 1'b0;
    end
    else
    begin
      sysref_d_reg <= sysref_i;
      if (sysref_rise)
      begin
        win_cnt_reg <= win_last ? 2'h0 : 2'(win_cnt_reg + 2'h1);
        if (edge_cnt_reg != `SRW_EDGES_VALID)
          edge_cnt_reg <= 2'(edge_cnt_reg + 2'h1);
        if (edge_cnt_reg == 2'(`SRW_EDGES_VALID - 1))
          valid_reg <= 1'b1;
      end
    end
  end

  // A tap is suspect when its neighbours saw SYSREF differently
  assign near_vec[0]      = 1'b1;
  assign near_vec[TAPS-1] = 1'b1;

  genvar gi;
  generate
    for (gi = 1; gi < TAPS - 1; gi++)
    begin : g_near
      assign near_vec[gi] = sysref_taps_i[gi-1] != sysref_taps_i[gi+1];
    end
    for (gi = 0; gi < TAPS; gi++)
    begin : g_judge
      srw_tap_judge u_judge
      (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .edge_i    (sysref_rise),
        .publish_i (win_last),
        .near_i    (near_vec[gi]),
        .flag_o    (judge_flag[gi])
      );
    end
  endgenerate

  // End taps cannot be judged
  wire [TAPS-1:0] pos_vec = judge_flag | {1'b1, {(TAPS-2){1'b0}}, 1'b1};

  // ===================================================================
  // SYSREF latch at the selected tap
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      latched_reg <= 1'b0;
      capture_reg <= 1'b0;
    end
    else
    begin
      latched_reg <= sysref_taps_i[sel_reg];
      capture_reg <= sysref_taps_i[sel_reg] && !latched_reg;
    end
  end

  assign sysref_latched_o     = latched_reg;
  assign sysref_capture_o     = capture_reg;
  assign sysref_tap_spacing_o = spacing_reg;
  assign dual_edge_sample_o   = single_reg;

  // ===================================================================
  // Read channel
  wire [9:0] rd_idx = s_araddr_i[11:2];
  wire rd_ramp = rd_idx == `SRW_IDX_RAMP;
  wire rd_ctrl = rd_idx == `SRW_IDX_CTRL;
  wire rd_low  = rd_idx == `SRW_IDX_POS_LOW;
  wire rd_mid  = rd_idx == `SRW_IDX_POS_MID;
  wire rd_high = rd_idx == `SRW_IDX_POS_HIGH;
  wire rd_stat = rd_idx == `SRW_IDX_WIN_STATUS;
  wire rd_known = rd_ramp || rd_ctrl || rd_low || rd_mid || rd_high || rd_stat;
  wire [31:0] rd_ramp_w = {7'h00, (ramp_state_reg == srw_pkg::SRW_RAMP_RUN), applied_reg,
                           6'h00, speed_reg, ramp_en_reg, target_reg};
  wire [31:0] rd_ctrl_w = {26'h0, single_reg, spacing_reg, sel_reg};
  wire [31:0] rd_mux =
      rd_ramp ? rd_ramp_w :
      rd_ctrl ? rd_ctrl_w :
      rd_low  ? {24'h000000, pos_vec[7:0]} :
      rd_mid  ? {24'h000000, pos_vec[15:8]} :
      rd_high ? {24'h000000, pos_vec[23:16]} :
      rd_stat ? {29'h0, edge_cnt_reg, valid_reg} : 32'h00000000;

  assign s_arready_o = !rvalid_reg;
  assign s_rvalid_o  = rvalid_reg;
  assign s_rdata_o   = rdata_reg;
  assign s_rresp_o   = rresp_reg;

  // Read data registered one cycle after the address
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= RESP_OKAY;
    end
    else if (s_arvalid_i && !rvalid_reg)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= rd_known ? RESP_OKAY : RESP_DECERR;
    end
    else if (s_rready_i)
      rvalid_reg <= 1'b0;
  end
endmodule

//--- sim/srw_clock_source_model.sv
// Clock source model driving SYSREF and its delayed tap copies
`timescale 1ns/1ns
module srw_clock_source_model
(
  input  wire logic        clock_i,
  input  wire logic        fire_i,
  input  wire logic        slow_i,
  input  wire logic [23:0] pat_i,
  output logic             sysref_o,
  output logic [23:0]      taps_o,
  output logic             busy_o
);
  logic [5:0] cnt_reg = 6'h00;
  // =====================================================================
  // Pulse timer: short or long SYSREF high time, fixed low gap
  always @(posedge clock_i)
  begin
    if (fire_i && cnt_reg == 6'h00)
      cnt_reg <= slow_i ? 6'h28 : 6'h10;
    else if (cnt_reg != 6'h00)
      cnt_reg <= cnt_reg - 6'h01;
  end
  // Taps follow SYSREF at each delayed rising-edge copy
  assign sysref_o = cnt_reg > 6'h0C;
  assign taps_o   = sysref_o ? pat_i : 24'h000000;
  assign busy_o   = cnt_reg != 6'h00;
endmodule

//--- sim/srw_top_monitor.sv
// Port checker for the SYSREF window block
`timescale 1ns/1ns
module srw_top_monitor
(
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        s_awvalid_i,
  input wire logic        s_awready_o,
  input wire logic        s_wvalid_i,
  input wire logic        s_wready_o,
  input wire logic [1:0]  s_bresp_o,
  input wire logic        s_bvalid_o,
  input wire logic        s_bready_i,
  input wire logic        s_arvalid_i,
  input wire logic        s_arready_o,
  input wire logic [31:0] s_rdata_o,
  input wire logic        s_rvalid_o,
  input wire logic        s_rready_i,
  input wire logic        sysref_capture_o,
  input wire logic        sysref_latched_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // =====================================================================
  // Bus answers
  AST_B_HOLD: assert property (s_bvalid_o && !s_bready_i |=> s_bvalid_o && $stable(s_bresp_o))
    else $error("write answer dropped");
  AST_R_HOLD: assert property (s_rvalid_o && !s_rready_i |=> s_rvalid_o && $stable(s_rdata_o))
    else $error("read answer dropped");
  AST_R_ANS: assert property (s_arvalid_i && s_arready_o |=> s_rvalid_o)
    else $error("late read answer");
  AST_B_ANS: assert property (s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o
    |=> s_bvalid_o)
    else $error("late write answer");
  AST_B_BLOCK: assert property (s_bvalid_o |-> !s_awready_o && !s_wready_o)
    else $error("write taken while answering");
  AST_AR_BLOCK: assert property (s_rvalid_o |-> !s_arready_o)
    else $error("read taken while answering");
  // =====================================================================
  // Capture pulse
  AST_CAP_AFTER: assert property ($rose(sysref_latched_o) |-> sysref_capture_o)
    else $error("no capture pulse");
  AST_CAP_PULSE: assert property (sysref_capture_o |=> !sysref_capture_o)
    else $error("capture too long");
  AST_CAP_CAUSE: assert property (sysref_capture_o |->
    sysref_latched_o && !$past(sysref_latched_o))
    else $error("capture without rise");
endmodule
bind srw_top srw_top_monitor srw_top_monitor_inst
(
  .clock_i(clock_i), .rst_n_i(rst_n_i), .s_awvalid_i(s_awvalid_i), .s_awready_o(s_awready_o),
  .s_wvalid_i(s_wvalid_i), .s_wready_o(s_wready_o), .s_bresp_o(s_bresp_o),
  .s_bvalid_o(s_bvalid_o), .s_bready_i(s_bready_i), .s_arvalid_i(s_arvalid_i),
  .s_arready_o(s_arready_o), .s_rdata_o(s_rdata_o), .s_rvalid_o(s_rvalid_o),
  .s_rready_i(s_rready_i), .sysref_capture_o(sysref_capture_o),
  .sysref_latched_o(sysref_latched_o)
);

//--- sim/test_sysref_window_and_delay_ramp.sv
// Testbench for the SYSREF window and delay ramp block
`timescale 1ns/1ns
`include "srw_defines.svh"
module test_sysref_window_and_delay_ramp;
  localparam logic [11:0] A_RAMP = {`SRW_IDX_RAMP, 2'b00};
  localparam logic [11:0] A_CTRL = {`SRW_IDX_CTRL, 2'b00};
  localparam logic [11:0] A_POS  = {`SRW_IDX_POS_LOW, 2'b00};
  localparam logic [11:0] A_STAT = {`SRW_IDX_WIN_STATUS, 2'b00};
  logic        clock_i = 1'b0, rst_n_i = 1'b0, fire = 1'b0, slow = 1'b0, busy;
  logic [11:0] s_awaddr_i = 12'h000, s_araddr_i = 12'h000;
  logic [31:0] s_wdata_i = 32'h0, s_rdata_o, seed = 32'h8668882E;
  logic [3:0]  s_wstrb_i = 4'hF;
  logic        s_awvalid_i = 1'b0, s_wvalid_i = 1'b0, s_bready_i = 1'b0;
  logic        s_arvalid_i = 1'b0, s_rready_i = 1'b0;
  logic        s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o, sysref_i;
  logic        sysref_tap_spacing_o, dual_edge_sample_o, sysref_capture_o, sysref_latched_o;
  logic [1:0]  s_bresp_o, s_rresp_o, exp_b[$];
  logic [23:0] sysref_taps_i, pat = 24'h0, ev;
  logic [7:0]  coarse_clock_delay_o;
  logic [33:0] exp_r[$];
  int          errors = 0, tests_run = 0, cyc = 0, caps = 0, n, p;
  always #2 clock_i = ~clock_i;
  srw_top srw_top_inst
  (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .s_awaddr_i(s_awaddr_i), .s_awvalid_i(s_awvalid_i),
    .s_awready_o(s_awready_o), .s_wdata_i(s_wdata_i), .s_wstrb_i(s_wstrb_i),
    .s_wvalid_i(s_wvalid_i), .s_wready_o(s_wready_o), .s_bresp_o(s_bresp_o),
    .s_bvalid_o(s_bvalid_o), .s_bready_i(s_bready_i), .s_araddr_i(s_araddr_i),
    .s_arvalid_i(s_arvalid_i), .s_arready_o(s_arready_o), .s_rdata_o(s_rdata_o),
    .s_rresp_o(s_rresp_o), .s_rvalid_o(s_rvalid_o), .s_rready_i(s_rready_i),
    .sysref_i(sysref_i), .sysref_taps_i(sysref_taps_i),
    .coarse_clock_delay_o(coarse_clock_delay_o), .sysref_tap_spacing_o(sysref_tap_spacing_o),
    .dual_edge_sample_o(dual_edge_sample_o), .sysref_capture_o(sysref_capture_o),
    .sysref_latched_o(sysref_latched_o)
  );
  srw_clock_source_model srw_clock_source_model_inst
  (
    .clock_i(clock_i), .fire_i(fire), .slow_i(slow), .pat_i(pat),
    .sysref_o(sysref_i), .taps_o(sysref_taps_i), .busy_o(busy)
  );
  // =====================================================================
  // Compare, verdict, random source
  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    tests_run++;
    if (seen !== want)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, want);
    end
  endtask
  task test_done;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // =====================================================================
  // Bus master, pulse and wait helpers
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_b.push_back(r);
    s_awaddr_i  <= a;
    s_wdata_i   <= d;
    s_awvalid_i <= 1'b1;
    s_wvalid_i  <= 1'b1;
    s_bready_i  <= 1'b1;
    do
    begin
      @(posedge clock_i);
      if (s_awready_o) s_awvalid_i <= 1'b0;
      if (s_wready_o) s_wvalid_i <= 1'b0;
    end while (!(s_bvalid_o === 1'b1));
    s_bready_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    exp_r.push_back(e);
    s_araddr_i  <= a;
    s_arvalid_i <= 1'b1;
    s_rready_i  <= 1'b1;
    do
    begin
      @(posedge clock_i);
      if (s_arready_o) s_arvalid_i <= 1'b0;
    end while (!(s_rvalid_o === 1'b1));
    s_rready_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic pulse(input logic [23:0] pt);
    pat  <= pt;
    fire <= 1'b1;
    @(posedge clock_i);
    fire <= 1'b0;
    do @(posedge clock_i); while (busy);
    @(posedge clock_i);
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clock_i);
  endtask
  // =====================================================================
  // Result watcher and timeout
  always @(posedge clock_i)
  begin
    cyc++;
    if (s_rvalid_o === 1'b1 && s_rready_i)
      check({s_rresp_o, s_rdata_o}, exp_r.pop_front());
    if (s_bvalid_o === 1'b1 && s_bready_i)
      check({32'h0, s_bresp_o}, {32'h0, exp_b.pop_front()});
    if (sysref_capture_o === 1'b1) caps++;
    if (cyc == 20000)
    begin
      errors++;
      test_done();
    end
  end
  // =====================================================================
  // Main sequence
  initial
  begin
    wt(3);
    rst_n_i <= 1'b1;
    rd(A_RAMP, 34'h0); rd(A_CTRL, 34'h0); rd(A_STAT, 34'h0);
    for (int i = 0; i < 3; i++) rd(A_POS + 12'(4 * i), 34'hFF);
    rd(12'h000, {2'b11, 32'h0});
    wr(12'h000, 32'h1, 2'b11);
    wr(A_POS, 32'h0, 2'b00);
    rd(A_POS, 34'hFF);
    // Every selectable tap latches, others are ignored
    for (int k = 0; k < 16; k++)
    begin
      wr(A_CTRL, 32'(k) | 32'((k % 4) << 4), 2'b00);
      check({33'h0, sysref_tap_spacing_o}, 34'(k % 2));
      check({33'h0, dual_edge_sample_o}, 34'((k / 2) % 2));
      n = caps;
      pulse(24'(rnd()) | (24'h1 << k));
      check(34'(caps - n), 34'h1);
      pulse(24'(rnd()) & ~(24'h1 << k));
      check(34'(caps - n), 34'h1);
    end
    // Fresh start, then position vector over two refresh rounds
    rst_n_i <= 1'b0;
    wt(2);
    rst_n_i <= 1'b1;
    for (int r = 0; r < 2; r++)
    begin
      slow <= r[0];
      p = 2 + rnd() % 20;
      ev = 24'h800001 | (24'h3 << (p - 1));
      pulse((24'h1 << p) - 24'h1);
      pulse((24'h1 << p) - 24'h1);
      rd(A_STAT, r ? 34'h7 : 34'h4);
      pulse((24'h1 << p) - 24'h1);
      rd(A_STAT, 34'h7);
      for (int i = 0; i < 3; i++) rd(A_POS + 12'(4 * i), 34'(ev[8 * i +: 8]));
    end
    // Middle of the good run below the edge, then calibration-safe select
    wr(A_CTRL, 32'((p - 1) / 2), 2'b00);
    rd(A_CTRL, 34'((p - 1) / 2));
    wr(A_CTRL, 32'h10, 2'b00);
    check({33'h0, sysref_tap_spacing_o}, 34'h1);
    // Direct coarse write, slow ramp, restart, fast ramp
    wr(A_RAMP, 32'h105, 2'b00);
    wt(2);
    check(34'(coarse_clock_delay_o), 34'h5);
    wr(A_RAMP, 32'h107, 2'b00);
    wt(250);
    check(34'(coarse_clock_delay_o), 34'h5);
    wt(12);
    check(34'(coarse_clock_delay_o), 34'h6);
    wr(A_RAMP, 32'h108, 2'b00);
    wt(250);
    check(34'(coarse_clock_delay_o), 34'h6);
    wt(12);
    check(34'(coarse_clock_delay_o), 34'h7);
    wr(A_RAMP, 32'h30D, 2'b00);
    wt(378);
    check(34'(coarse_clock_delay_o), 34'h7);
    wt(12);
    check(34'(coarse_clock_delay_o), 34'hB);
    wt(384);
    check(34'(coarse_clock_delay_o), 34'hD);
    rd(A_RAMP, 34'h000D030D);
    test_done();
  end
endmodule
